// ===== src/ifd_core.sv
`timescale 1ns/10ps
`include "ifd_regs.svh"

module ifd_core #(
  parameter logic [31:0] RESET_PC = `IFD_RESET_PC
) (
  input wire logic core_clk,
  input wire logic rst,
  output logic fetchReq,
  output logic [31:0] fetchAddr,
  input wire logic [15:0] fetchData,
  input wire logic fetchAck,
  output logic wbValid,
  output logic [4:0] wbIdx,
  output logic [31:0] wbData,
  output logic carryFlag,
  output logic signedRangeFlag,
  output logic negativeFlag,
  output logic equalResultFlag,
  output logic branchTaken
);
  import ifd_pkg::*;

  ifd_state_t state_q;
  logic [31:0] pc_q;
  logic [31:0] insn_q;
  logic [31:0] gpr [32];
  logic [5:0] opc;
  logic [4:0] dstField, srcField, shortImm, wrIdx;
  logic [2:0] brOpc;
  logic [3:0] condCode;
  logic [8:0] branchOffset;
  logic [25:0] jumpOffset;
  logic [15:0] wideField;
  logic [5:0] subOpc;
  logic isLong, condHolds, brTaken, jmpTaken;
  ifd_op_t op;
  logic [31:0] srcVal, dstVal, aluRes, nextPc;
  logic carryN, rangeN, sN, zN;

  // ==========================================
  // Field extraction from the assembled word
  assign opc = insn_q[`IFD_OPC_HI:`IFD_OPC_LO];
  assign dstField = insn_q[`IFD_DST_HI:`IFD_DST_LO];
  assign srcField = insn_q[`IFD_SRC_HI:`IFD_SRC_LO];
  assign shortImm = insn_q[`IFD_SRC_HI:`IFD_SRC_LO];
  assign brOpc = insn_q[`IFD_BOPC_HI:`IFD_BOPC_LO];
  assign condCode = insn_q[`IFD_COND_HI:`IFD_COND_LO];
  assign branchOffset = {insn_q[`IFD_BOFS_HI:`IFD_BOFS_LO], 1'b0};
  assign jumpOffset = {insn_q[`IFD_DST_HI:`IFD_SRC_LO], insn_q[`IFD_WIDE_HI:`IFD_WIDE_LO + 1], 1'b0};
  assign wideField = insn_q[`IFD_WIDE_HI:`IFD_WIDE_LO];
  assign subOpc = insn_q[`IFD_SUB_HI:`IFD_SUB_LO];
  assign isLong = (opc >= `IFD_LONG_MIN) && (brOpc != `IFD_BOPC_BRANCH);

  // ==========================================
  // Operation select and operand routing
  always_comb begin
    op = OP_NONE;
    srcVal = gpr[srcField];
    dstVal = gpr[dstField];
    wrIdx = dstField;
    if (brOpc != `IFD_BOPC_BRANCH) begin
      unique case (opc)
        `IFD_OPC_ADD_R: op = OP_ADD;
        `IFD_OPC_AND_R: op = OP_AND;
        `IFD_OPC_ADD_I: begin
          op = OP_ADD;
          srcVal = {{27{shortImm[4]}}, shortImm};
        end
        `IFD_OPC_ADD_W, `IFD_OPC_AND_W: begin
          op = (opc == `IFD_OPC_ADD_W) ? OP_ADD : OP_AND_W;
          srcVal = {{16{wideField[15]}}, wideField};
          dstVal = gpr[srcField];
        end
        `IFD_OPC_EXT: if (subOpc == `IFD_SUB_FADD) op = OP_FADD;
        `IFD_OPC_BITSTR: begin
          if (shortImm == `IFD_BS_AND) op = OP_BSAND;
          if (shortImm == `IFD_BS_ANDN) op = OP_BSANDN;
          srcVal = gpr[`IFD_BS_SRC_REG];
          dstVal = gpr[`IFD_BS_DST_REG];
          wrIdx = `IFD_BS_DST_REG;
        end
        default: op = OP_NONE;
      endcase
    end
  end

  // ==========================================
  // Branch condition and next address
  always_comb begin
    unique case (condCode)
      `IFD_CC_CARRY: condHolds = carryFlag;
      `IFD_CC_EQUAL: condHolds = equalResultFlag;
      `IFD_CC_GE: condHolds = !(negativeFlag ^ signedRangeFlag);
      `IFD_CC_GT: condHolds = !((negativeFlag ^ signedRangeFlag) | equalResultFlag);
      default: condHolds = 1'b0;
    endcase
    brTaken = (brOpc == `IFD_BOPC_BRANCH) && condHolds;
    jmpTaken = !isLong ? 1'b0 : (opc == `IFD_OPC_JUMP);
    if (brTaken) nextPc = pc_q + {{23{branchOffset[8]}}, branchOffset};
    else if (jmpTaken) nextPc = pc_q + {{6{jumpOffset[25]}}, jumpOffset};
    else nextPc = pc_q + (isLong ? `IFD_WORD_STEP : `IFD_HALF_STEP);
  end

  ifd_alu u_alu (
    .op(op),
    .srcVal(srcVal),
    .dstVal(dstVal),
    .carryIn(carryFlag),
    .rangeIn(signedRangeFlag),
    .sIn(negativeFlag),
    .zIn(equalResultFlag),
    .result(aluRes),
    .carryOut(carryN),
    .rangeOut(rangeN),
    .sOut(sN),
    .zOut(zN)
  );

  // ==========================================
  // Fetch sequencer and halfword assembly
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= FETCH_LO;
      fetchReq <= 1'b1;
      fetchAddr <= RESET_PC;
      pc_q <= RESET_PC;
      insn_q <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        FETCH_LO: if (fetchAck) begin
          insn_q <= {16'h0000, fetchData};
          if (fetchData[`IFD_OPC_HI:`IFD_OPC_LO] >= `IFD_LONG_MIN &&
              fetchData[`IFD_BOPC_HI:`IFD_BOPC_LO] != `IFD_BOPC_BRANCH) begin
            state_q <= FETCH_HI;
            fetchAddr <= pc_q + `IFD_HALF_STEP;
          end else begin
            state_q <= EXEC;
            fetchReq <= 1'b0;
          end
        end
        FETCH_HI: if (fetchAck) begin
          insn_q[31:16] <= fetchData;
          state_q <= EXEC;
          fetchReq <= 1'b0;
        end
        EXEC: begin
          pc_q <= nextPc;
          fetchAddr <= nextPc;
          fetchReq <= 1'b1;
          state_q <= FETCH_LO;
        end
      endcase
    end
  end

  // ==========================================
  // Flags, write-back report, branch pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      carryFlag <= 1'b0;
      signedRangeFlag <= 1'b0;
      negativeFlag <= 1'b0;
      equalResultFlag <= 1'b0;
      wbValid <= 1'b0;
      wbIdx <= 5'h00;
      wbData <= 32'h0000_0000;
      branchTaken <= 1'b0;
    end else begin
      wbValid <= (state_q == EXEC) && (op != OP_NONE);
      branchTaken <= (state_q == EXEC) && brTaken;
      if (state_q == EXEC && op != OP_NONE) begin
        carryFlag <= carryN;
        signedRangeFlag <= rangeN;
        negativeFlag <= sN;
        equalResultFlag <= zN;
        wbIdx <= wrIdx;
        wbData <= aluRes;
      end
    end
  end

  // General-purpose register array, written in the execute cycle
  always_ff @(posedge core_clk) begin
    if (state_q == EXEC && op != OP_NONE) gpr[wrIdx] <= aluRes;
  end

  // ==========================================
  // Checks
  a_half_low: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == FETCH_LO && fetchAck) |=> insn_q[15:0] == $past(fetchData))
    else $error("low halfword not taken first");
  a_long_fetch: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == FETCH_HI) |-> fetchReq && fetchAddr == pc_q + `IFD_HALF_STEP)
    else $error("upper halfword address wrong");
  a_add_sum: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == EXEC && op == OP_ADD) |=> wbValid && wbData == $past(srcVal + dstVal)
      && equalResultFlag == (wbData == 32'h0000_0000) && negativeFlag == wbData[31])
    else $error("add result or flags wrong");
  a_short_ext: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == EXEC && opc == `IFD_OPC_ADD_I && brOpc != `IFD_BOPC_BRANCH)
      |-> srcVal[31:4] == {28{shortImm[4]}})
    else $error("short immediate not sign-extended");
  a_fadd_range: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == EXEC && op == OP_FADD) |=> !signedRangeFlag && carryFlag == wbData[31])
    else $error("float add flags wrong");
  a_and_carry: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == EXEC && (op == OP_AND || op == OP_AND_W)) |=> $stable(carryFlag) && !signedRangeFlag)
    else $error("and touched carry or overflow");
  a_andw_neg: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == EXEC && op == OP_AND_W) |=> !negativeFlag && wbData == $past(srcVal & dstVal))
    else $error("wide and sign flag not cleared");
  a_bs_flags: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == EXEC && (op == OP_BSAND || op == OP_BSANDN)) |=>
      $stable(carryFlag) && $stable(signedRangeFlag) && $stable(negativeFlag) && $stable(equalResultFlag))
    else $error("bit-string op changed flags");
  a_branch_tgt: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == EXEC && brTaken) |=> branchTaken && $stable(carryFlag) && $stable(equalResultFlag)
      && fetchAddr == $past(pc_q) + {{23{$past(branchOffset[8])}}, $past(branchOffset)})
    else $error("branch target wrong");

endmodule : ifd_core

// ===== include/ifd_regs.svh
`ifndef IFD_REGS_SVH
`define IFD_REGS_SVH

// ==========================================
// Field positions of the instruction word
`define IFD_OPC_HI 15
`define IFD_OPC_LO 10
`define IFD_DST_HI 9
`define IFD_DST_LO 5
`define IFD_SRC_HI 4
`define IFD_SRC_LO 0
`define IFD_BOPC_HI 15
`define IFD_BOPC_LO 13
`define IFD_COND_HI 12
`define IFD_COND_LO 9
`define IFD_BOFS_HI 8
`define IFD_BOFS_LO 1
`define IFD_WIDE_HI 31
`define IFD_WIDE_LO 16
`define IFD_SUB_HI 31
`define IFD_SUB_LO 26

// ==========================================
// Opcode values
`define IFD_LONG_MIN 6'h28
`define IFD_OPC_ADD_R 6'h01
`define IFD_OPC_AND_R 6'h0D
`define IFD_OPC_ADD_I 6'h11
`define IFD_OPC_BITSTR 6'h1F
`define IFD_OPC_JUMP 6'h2A
`define IFD_OPC_ADD_W 6'h29
`define IFD_OPC_AND_W 6'h2D
`define IFD_OPC_EXT 6'h3E
`define IFD_SUB_FADD 6'h04
`define IFD_BS_AND 5'h09
`define IFD_BS_ANDN 5'h0D
`define IFD_BOPC_BRANCH 3'h4

// ==========================================
// Condition codes
`define IFD_CC_CARRY 4'h1
`define IFD_CC_EQUAL 4'h2
`define IFD_CC_GE 4'hE
`define IFD_CC_GT 4'hF

// ==========================================
// Fixed bit-string registers, reset PC, address steps
`define IFD_BS_SRC_REG 5'h1E
`define IFD_BS_DST_REG 5'h1D
`define IFD_RESET_PC 32'h0000_0000
`define IFD_HALF_STEP 32'h0000_0002
`define IFD_WORD_STEP 32'h0000_0004

`endif

// ===== include/ifd_pkg.sv
package ifd_pkg;

  // ==========================================
  // Sequencer states
  typedef enum logic [1:0] {
    FETCH_LO,
    FETCH_HI,
    EXEC
  } ifd_state_t;

  // ==========================================
  // Operations carried out by the datapath
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD,
    OP_FADD,
    OP_AND,
    OP_AND_W,
    OP_BSAND,
    OP_BSANDN
  } ifd_op_t;

endpackage : ifd_pkg

// ===== src/ifd_alu.sv
`timescale 1ns/10ps
module ifd_alu (
  input wire ifd_pkg::ifd_op_t op,
  input wire logic [31:0] srcVal,
  input wire logic [31:0] dstVal,
  input wire logic carryIn,
  input wire logic rangeIn,
  input wire logic sIn,
  input wire logic zIn,
  output logic [31:0] result,
  output logic carryOut,
  output logic rangeOut,
  output logic sOut,
  output logic zOut
);
  import ifd_pkg::*;

  logic [32:0] sum;
  logic [7:0] fEx, fEy, fSh;
  logic [23:0] fMx, fMy, fMyS;
  logic fSx, fSy;
  logic [24:0] fSum, fNorm;
  logic [4:0] lz;
  logic [9:0] fExp;
  logic [31:0] fRes;

  // ==========================================
  // Single-precision add, truncating, denormals flushed
  always_comb begin
    if ({srcVal[30:23], srcVal[22:0]} >= {dstVal[30:23], dstVal[22:0]}) begin
      {fSx, fEx, fMx[22:0]} = srcVal;
      {fSy, fEy, fMy[22:0]} = dstVal;
    end else begin
      {fSx, fEx, fMx[22:0]} = dstVal;
      {fSy, fEy, fMy[22:0]} = srcVal;
    end
    fMx[23] = |fEx;
    fMy[23] = |fEy;
    if (fEx == 8'h00) fMx = 24'h00_0000; // Flush denormal
    if (fEy == 8'h00) fMy = 24'h00_0000;
    fSh = fEx - fEy;
    fMyS = (fSh > 8'd24) ? 24'h00_0000 : (fMy >> fSh);
    fSum = (fSx == fSy) ? ({1'b0, fMx} + {1'b0, fMyS}) : ({1'b0, fMx} - {1'b0, fMyS});
    lz = 5'd0;
    for (int i = 0; i < 24; i++) begin
      if (fSum[i]) lz = 5'(23 - i);
    end
    fNorm = fSum << lz;
    if (fSum[24]) begin
      fExp = {2'b00, fEx} + 10'd1;
      fRes = {fSx, fExp[7:0], fSum[23:1]};
    end else begin
      fExp = {2'b00, fEx} - {5'b00000, lz};
      fRes = {fSx, fExp[7:0], fNorm[22:0]};
    end
    if (fSum == 25'h000_0000 || fExp[9] || fExp == 10'd0) fRes = 32'h0000_0000;
    else if (fExp >= 10'd255) fRes = {fSx, 8'hFF, 23'h00_0000}; // Saturate to infinity
  end

  // ==========================================
  // Result and flags: set, preserved or cleared per operation
  always_comb begin
    sum = {1'b0, srcVal} + {1'b0, dstVal};
    result = 32'h0000_0000;
    carryOut = carryIn;
    rangeOut = rangeIn;
    sOut = sIn;
    zOut = zIn;
    unique case (op)
      OP_ADD: begin
        result = sum[31:0];
        carryOut = sum[32];
        rangeOut = (srcVal[31] == dstVal[31]) && (sum[31] != srcVal[31]);
        sOut = sum[31];
        zOut = (sum[31:0] == 32'h0000_0000);
      end
      OP_FADD: begin
        result = fRes;
        carryOut = fRes[31];
        rangeOut = 1'b0;
        sOut = fRes[31];
        zOut = (fRes[30:0] == 31'h0000_0000);
      end
      OP_AND: begin
        result = srcVal & dstVal;
        rangeOut = 1'b0;
        sOut = result[31];
        zOut = (result == 32'h0000_0000);
      end
      OP_AND_W: begin
        result = srcVal & dstVal;
        rangeOut = 1'b0;
        sOut = 1'b0;
        zOut = (result == 32'h0000_0000);
      end
      OP_BSAND: result = dstVal & srcVal;
      OP_BSANDN: result = dstVal & ~srcVal;
      OP_NONE: result = 32'h0000_0000;
      default: result = 32'h0000_0000;
    endcase
  end

endmodule : ifd_alu

// ===== sim/ifd_fetch_model.sv
`timescale 1ns/10ps
module ifd_fetch_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic fetchReq,
  input wire logic [31:0] fetchAddr,
  input wire logic slowMode,
  output logic [15:0] fetchData,
  output logic fetchAck
);
  logic [15:0] mem [0:16383];
  logic [1:0] waitCnt = 2'h0;

  // ==========================================
  // Memory and answer lines
  initial begin
    fetchAck = 1'b0;
    fetchData = 16'h0000;
    foreach (mem[i]) mem[i] = 16'h0000;
  end

  // Answer at falling edge; slow mode waits on address bits; idle data toggles
  always @(negedge core_clk) begin
    if (!rst && fetchReq && (!slowMode || waitCnt >= fetchAddr[2:1])) begin
      fetchAck <= 1'b1;
      fetchData <= mem[fetchAddr[14:1]];
      waitCnt <= 2'h0;
    end else begin
      fetchAck <= 1'b0;
      fetchData <= ~fetchData;
      waitCnt <= fetchReq ? waitCnt + 2'h1 : 2'h0;
    end
  end
endmodule : ifd_fetch_model

// ===== sim/insn_format_decode_add_and_branch_test.sv
`timescale 1ns/10ps
`include "ifd_regs.svh"
module insn_format_decode_add_and_branch_test;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic slowMode = 1'b0;
  logic fetchReq, fetchAck, wbValid, branchTaken;
  logic carryFlag, signedRangeFlag, negativeFlag, equalResultFlag;
  logic [31:0] fetchAddr, wbData;
  logic [15:0] fetchData;
  logic [4:0] wbIdx;
  logic [31:0] gpr [0:31];
  logic [31:0] pc = `IFD_RESET_PC;
  logic [3:0] flg = 4'h0;
  logic [31:0] fetchQ [$];
  logic [31:0] dataQ [$];
  logic [3:0] flagQ [$];
  logic [4:0] idxQ [$];
  int seed = 32'h21d18333;
  int miscompares = 0;
  int totalChecks = 0;
  int takenExp = 0;
  int takenSeen = 0;

  // ==========================================
  // Clock, design and fetch side
  always #5 core_clk = ~core_clk;

  ifd_core DUT (.core_clk(core_clk), .rst(rst), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .fetchData(fetchData), .fetchAck(fetchAck), .wbValid(wbValid), .wbIdx(wbIdx), .wbData(wbData),
    .carryFlag(carryFlag), .signedRangeFlag(signedRangeFlag), .negativeFlag(negativeFlag),
    .equalResultFlag(equalResultFlag), .branchTaken(branchTaken));

  ifd_fetch_model fm (.core_clk(core_clk), .rst(rst), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .slowMode(slowMode), .fetchData(fetchData), .fetchAck(fetchAck));

  // ==========================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic emit(input logic [31:0] w, input logic isLong);
    fm.mem[pc[14:1]] = w[15:0];
    fetchQ.push_back(pc);
    if (isLong) begin
      fm.mem[pc[14:1] + 14'h0001] = w[31:16];
      fetchQ.push_back(pc + 32'h0000_0002);
    end
    pc = pc + (isLong ? 32'h0000_0004 : 32'h0000_0002);
  endtask : emit

  task automatic wr(input logic [4:0] d, input logic [31:0] v, input logic [3:0] f);
    gpr[d] = v;
    flg = f;
    idxQ.push_back(d);
    dataQ.push_back(v);
    flagQ.push_back(f);
  endtask : wr

  function automatic logic [3:0] addF(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] r;
    r = {1'b0, a} + {1'b0, b};
    return {r[32], (a[31] == b[31]) && (r[31] != a[31]), r[31], r[31:0] == 32'h0000_0000};
  endfunction : addF

  // Exact for equal or opposite operands only
  function automatic logic [31:0] fsum(input logic [31:0] a, input logic [31:0] b);
    if (a == (b ^ 32'h8000_0000)) return 32'h0000_0000;
    return {a[31], a[30:23] + 8'h01, a[22:0]};
  endfunction : fsum

  // Place one instruction at pc and work out its effects
  task automatic step(input int kind, input logic [4:0] d, input logic [4:0] s, input logic [15:0] imm);
    logic [31:0] w, v, x;
    logic [3:0] cc;
    logic [14:0] k;
    w = {{16{imm[15]}}, imm};
    x = {{27{imm[4]}}, imm[4:0]};
    k = {8'h00, imm[6:0]} | 15'h0002;
    cc = imm[9] ? (imm[8] ? `IFD_CC_GT : `IFD_CC_GE) : (imm[8] ? `IFD_CC_EQUAL : `IFD_CC_CARRY);
    if (imm[10]) cc = 4'h3;
    v = (kind == 5) ? gpr[`IFD_BS_SRC_REG] : ~gpr[`IFD_BS_SRC_REG];
    case (kind)
      0: begin
        emit({16'h0000, `IFD_OPC_ADD_R, d, s}, 1'b0);
        wr(d, gpr[d] + gpr[s], addF(gpr[d], gpr[s]));
      end
      1: begin
        emit({16'h0000, `IFD_OPC_ADD_I, d, imm[4:0]}, 1'b0);
        wr(d, gpr[d] + x, addF(gpr[d], x));
      end
      2: begin
        emit({imm, `IFD_OPC_ADD_W, d, s}, 1'b1);
        wr(d, gpr[s] + w, addF(gpr[s], w));
      end
      3: begin
        emit({16'h0000, `IFD_OPC_AND_R, d, s}, 1'b0);
        v = gpr[d] & gpr[s];
        wr(d, v, {flg[3], 1'b0, v[31], v == 32'h0000_0000});
      end
      4: begin
        emit({imm, `IFD_OPC_AND_W, d, s}, 1'b1);
        v = gpr[s] & w;
        wr(d, v, {flg[3], 2'h0, v == 32'h0000_0000});
      end
      5, 6: begin
        emit({16'h0000, `IFD_OPC_BITSTR, 5'h00, kind == 5 ? `IFD_BS_AND : `IFD_BS_ANDN}, 1'b0);
        wr(`IFD_BS_DST_REG, gpr[`IFD_BS_DST_REG] & v, flg);
      end
      7: begin
        emit({16'h0000, `IFD_BOPC_BRANCH, cc, 1'b0, imm[6:0] | 7'h01, imm[7]}, 1'b0);
        if ((cc == `IFD_CC_CARRY && flg[3]) || (cc == `IFD_CC_EQUAL && flg[0]) ||
            (cc == `IFD_CC_GE && !(flg[1] ^ flg[2])) || (cc == `IFD_CC_GT && !((flg[1] ^ flg[2]) | flg[0]))) begin
          pc = pc - 32'h0000_0002 + {24'h00_0000, imm[6:0] | 7'h01, 1'b0};
          takenExp++;
        end
      end
      8: emit({imm, 6'h30, d, s}, 1'b1);
      9: emit({6'h05, 10'h000, `IFD_OPC_EXT, d, s}, 1'b1);
      10: begin
        emit({k, 1'b1, `IFD_OPC_JUMP, 10'h000}, 1'b1);
        pc = pc - 32'h0000_0004 + {16'h0000, k, 1'b0};
      end
      default: begin
        emit({`IFD_SUB_FADD, 10'h000, `IFD_OPC_EXT, d, s}, 1'b1);
        v = fsum(gpr[d], gpr[s]);
        wr(d, v, {v[31], 1'b0, v[31], v[30:0] == 31'h0000_0000});
      end
    endcase
  endtask : step

  // ==========================================
  // Monitors
  always @(posedge core_clk) begin
    if (!rst && fetchReq && fetchAck && fetchQ.size() > 0) chk("fetchAddr", fetchAddr, fetchQ.pop_front());
  end

  // Results sampled where settled
  always @(negedge core_clk) begin
    if (!rst && wbValid === 1'b1) begin
      if (idxQ.size() == 0) chk("extraWrite", 32'h0000_0001, 32'h0000_0000);
      else begin
        chk("wbIdx", wbIdx, idxQ.pop_front());
        chk("wbData", wbData, dataQ.pop_front());
        chk("flags", {carryFlag, signedRangeFlag, negativeFlag, equalResultFlag}, flagQ.pop_front());
      end
    end
    if (!rst && branchTaken === 1'b1) takenSeen++;
  end

  // ==========================================
  // Main sequence
  initial begin
    int k;
    int r;
    // Let the fetch model clear its memory before the program is placed
    #1;
    for (k = 1; k <= 30; k++) begin
      if (k <= 10 || k >= 29) begin
        step(4, k[4:0], k[4:0], 16'h0000);
        step(2, k[4:0], k[4:0], k == 9 ? 16'h3F80 : k == 10 ? 16'hBF80 : 16'($random(seed)));
        if (k == 9 || k == 10) repeat (16) step(0, k[4:0], k[4:0], 16'h0000);
      end
    end
    step(11, 5'h09, 5'h09, 16'h0000);
    step(11, 5'h0A, 5'h0A, 16'h0000);
    step(11, 5'h09, 5'h0A, 16'h0000);
    for (k = 0; k < 150; k++) begin
      r = $random(seed);
      step($unsigned(r) % 11, 5'h01 + 5'(r[18:16]), 5'h01 + 5'(r[21:19]), 16'($random(seed)));
    end
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    chk("fetchReq", fetchReq, 32'h0000_0001);
    chk("fetchAddr", fetchAddr, `IFD_RESET_PC);
    chk("resetOuts", {wbValid, branchTaken, carryFlag, signedRangeFlag, negativeFlag, equalResultFlag}, 32'h0000_0000);
    rst = 1'b0;
    for (k = 0; k < 20000 && fetchQ.size() > 0; k++) begin
      @(posedge core_clk);
      slowMode <= fetchQ.size() < 150;
    end
    repeat (20) @(negedge core_clk);
    chk("writesLeft", idxQ.size(), 32'h0000_0000);
    chk("taken", takenSeen, takenExp);
    wrap_up();
  end

  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge core_clk);
    miscompares++;
    wrap_up();
  end
endmodule : insn_format_decode_add_and_branch_test
